// >>> hw/aesc_regs.svh
`ifndef AESC_REGS_SVH
`define AESC_REGS_SVH
// ------------------------------------------------------------
// register offsets (byte addresses on apb)
// ------------------------------------------------------------
`define AESC_OFS_CTRL1  12'h000
`define AESC_OFS_CTRL2  12'h004
`define AESC_OFS_IRQS2  12'h008
`define AESC_OFS_DATA0  12'h010
`define AESC_OFS_DATA3  12'h01C
// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define AESC_CTRL1_W    7
`define AESC_SEL_HI     7
`define AESC_SEL_LO     5
`define AESC_PASS_BIT   0
`define AESC_BUSY_BIT   1
`define AESC_DONE_BIT   0
`define AESC_SEL_KEY    3'h0
`define AESC_SEL_TEXT   3'h1
`define AESC_SEL_CNT    3'h2
`define AESC_SEL_CTRRES 3'h3
`define AESC_SEL_MAC    3'h4
`define AESC_SEL_STAGE  3'h5
`define AESC_SEL_CBCRES 3'h6
// ------------------------------------------------------------
// core timing: 10 rounds, result 11 clocks after start
// ------------------------------------------------------------
`define AESC_LAST_RND   4'hA
`define AESC_RCON0      8'h01
`define AESC_RCON_POLY  8'h1B
`endif

// >>> hw/aesc_pkg.sv
package aesc_pkg;
    // control register one, start in bit 0
    typedef struct packed {
        logic accumulator_load_bit;
        logic clear;
        logic selftest;
        logic aes;
        logic cbc;
        logic ctr;
        logic start;
    } aesc_ctrl_type;
    typedef enum logic [1:0] {AESC_IDLE, AESC_CTR_P, AESC_CBC_P} aesc_state_type;
endpackage

// >>> hw/aesc_engine.sv
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "aesc_regs.svh"
// Notes on behaviour
// - operands loaded first; start bit launches and clears itself after one cycle, taken or not.
// - engine stays disabled after reset until a self-test passes.
// - self-test bit plus start runs the test; pass sets pass flag.
// - failing test clears pass flag, disables engine, result reads give zero.
// - result readable in the window 11 clocks after start is set.
// - completion sets status bit and drives the completion output.
// - counter decryption uses the same path; ciphertext in, plaintext out.
// - with both counter and chaining set, counter pass first, then chaining.
// - no inverse cipher; plain decryption is not offered.
// - plain result lands in chaining result register, overwritten later.
// - core runs 11 cycles, pulses ready, holds complete; wrapper captures then.
// - counter mode encrypts counter, xors text, stores counter result.
// - chaining xors text with previous output; load bit presets feedback.
// - in self-test the chaining output feeds the core key.
// - ten rounds per block, new round key each round.
// - window writes steered by select: key, text, counter, stage.
// - select 011 reads counter result, 110 reads chaining result.
// - clear bit zeroes counter result and chaining accumulator.
// - select 100 reads the final chaining value.
// - select 101 stages an accumulator value; load bit copies it in.
module aesc_engine
    import aesc_pkg::*;
#(
    parameter logic [127:0] SELFTEST_EXPECT = 128'h66E9_4BD4_EF8A_2C3B_884C_FA59_CA34_2B2E
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // completion level
    output logic             done_irq
);
    localparam logic [2047:0] SBOX = {
        128'h637C_777B_F26B_6FC5_3001_672B_FED7_AB76, 128'hCA82_C97D_FA59_47F0_ADD4_A2AF_9CA4_72C0,
        128'hB7FD_9326_363F_F7CC_34A5_E5F1_71D8_3115, 128'h04C7_23C3_1896_059A_0712_80E2_EB27_B275,
        128'h0983_2C1A_1B6E_5AA0_523B_D6B3_29E3_2F84, 128'h53D1_00ED_20FC_B15B_6ACB_BE39_4A4C_58CF,
        128'hD0EF_AAFB_434D_3385_45F9_027F_503C_9FA8, 128'h51A3_408F_929D_38F5_BCB6_DA21_10FF_F3D2,
        128'hCD0C_13EC_5F97_4417_C4A7_7E3D_645D_1973, 128'h6081_4FDC_222A_9088_46EE_B814_DE5E_0BDB,
        128'hE032_3A0A_4906_245C_C2D3_AC62_9195_E479, 128'hE7C8_376D_8DD5_4EA9_6C56_F4EA_657A_AE08,
        128'hBA78_252E_1CA6_B4C6_E8DD_741F_4BBD_8B8A, 128'h703E_B566_4803_F60E_6135_57B9_86C1_1D9E,
        128'hE1F8_9811_69D9_8E94_9B1E_87E9_CE55_28DF, 128'h8CA1_890D_BFE6_4268_4199_2D0F_B054_BB16};

    // ------------------------------------------------------------
    // aes round helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] sb(input logic [7:0] b);
        sb = SBOX[2047 - 8 * b -: 8];
    endfunction
    function automatic logic [7:0] xt(input logic [7:0] b);
        xt = {b[6:0], 1'b0} ^ (b[7] ? `AESC_RCON_POLY : 8'h00);
    endfunction
    // byte i = bits [127-8i -: 8]; column c holds bytes 4c..4c+3
    function automatic logic [127:0] round_f(input logic [127:0] s, input logic [127:0] k,
                                             input logic last);
        logic [7:0]   a [16];
        logic [7:0]   r [16];
        logic [127:0] o;
        for (int i = 0; i < 16; i++) begin
            a[i] = sb(s[127 - 8 * i -: 8]);
        end
        for (int c = 0; c < 4; c++) begin
            for (int j = 0; j < 4; j++) begin
                r[4 * c + j] = a[4 * ((c + j) % 4) + j];
            end
        end
        for (int c = 0; c < 4; c++) begin
            o[127 - 32 * c -: 8] = last ? r[4*c] :
                xt(r[4*c]) ^ xt(r[4*c+1]) ^ r[4*c+1] ^ r[4*c+2] ^ r[4*c+3];
            o[119 - 32 * c -: 8] = last ? r[4*c+1] :
                r[4*c] ^ xt(r[4*c+1]) ^ xt(r[4*c+2]) ^ r[4*c+2] ^ r[4*c+3];
            o[111 - 32 * c -: 8] = last ? r[4*c+2] :
                r[4*c] ^ r[4*c+1] ^ xt(r[4*c+2]) ^ xt(r[4*c+3]) ^ r[4*c+3];
            o[103 - 32 * c -: 8] = last ? r[4*c+3] :
                xt(r[4*c]) ^ r[4*c] ^ r[4*c+1] ^ r[4*c+2] ^ xt(r[4*c+3]);
        end
        round_f = o ^ k;
    endfunction
    function automatic logic [127:0] kexp(input logic [127:0] k, input logic [7:0] rc);
        logic [31:0] t;
        logic [31:0] n0;
        logic [31:0] n1;
        logic [31:0] n2;
        t  = {sb(k[23:16]) ^ rc, sb(k[15:8]), sb(k[7:0]), sb(k[31:24])};
        n0 = k[127:96] ^ t;
        n1 = k[95:64] ^ n0;
        n2 = k[63:32] ^ n1;
        kexp = {n0, n1, n2, k[31:0] ^ n2};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    aesc_ctrl_type  ctl_reg, ctl_next, run_reg, run_next;
    aesc_state_type st_reg, st_next;
    logic [2:0]   sel_reg, sel_next;
    logic         pass_reg, pass_next, done_reg, done_next;
    logic         cdone_reg, cdone_next;
    logic [127:0] key_reg, key_next, txt_reg, txt_next, cnt_reg, cnt_next;
    logic [127:0] stg_reg, stg_next, ctr_reg, ctr_next, cbc_reg, cbc_next;
    logic [127:0] blk_reg, blk_next, rk_reg, rk_next;
    logic [7:0]   rc_reg, rc_next;
    logic [3:0]   rnd_reg, rnd_next;
    logic [31:0]  prd_reg, prd_next;
    logic         wr, rd_setup, mapped, launch, rdy, go_ctr, go_cbc, chain;
    logic [1:0]   widx;
    logic [6:0]   wbase;
    logic [127:0] cin, ckey, kx, cout, rdwin;

    // apb decode; zero wait states, data latched in setup
    assign wr       = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped   = paddr == `AESC_OFS_CTRL1 || paddr == `AESC_OFS_CTRL2 ||
                      paddr == `AESC_OFS_IRQS2 ||
                      (paddr >= `AESC_OFS_DATA0 && paddr <= `AESC_OFS_DATA3 &&
                       paddr[1:0] == 2'b00);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign prdata   = prd_reg;
    assign done_irq = done_reg;
    assign widx     = paddr[3:2];
    assign wbase    = 7'(96 - 32 * widx);                                   // lsb of addressed word

    // core datapath: round keys derived every round
    assign rdy  = rnd_reg == `AESC_LAST_RND;
    assign kx   = kexp(rk_reg, rc_reg);
    assign cout = round_f(blk_reg, kx, rdy);
    assign ckey = ctl_reg.selftest ? cbc_reg : key_reg;

    // launch decode; a disabled engine only accepts self-test starts,
    // and a start with no mode bit is dropped so the core never runs idle
    assign launch = ctl_reg.start && st_reg == AESC_IDLE &&
                    (ctl_reg.selftest ||
                     pass_reg && (ctl_reg.ctr || ctl_reg.cbc || ctl_reg.aes));
    assign go_ctr = launch && !ctl_reg.selftest && ctl_reg.ctr;
    assign go_cbc = launch && (ctl_reg.selftest || (!ctl_reg.ctr && (ctl_reg.cbc || ctl_reg.aes)));
    assign chain  = st_reg == AESC_CTR_P && rdy && run_reg.cbc;

    // core input mux per pass
    always_comb begin
        if (st_reg == AESC_CTR_P && !chain || go_ctr) begin
            cin = cnt_reg;
        end else if (ctl_reg.selftest) begin
            cin = '0;
        end else if (ctl_reg.cbc) begin
            cin = txt_reg ^ cbc_reg;
        end else begin
            cin = txt_reg;
        end
    end

    // window read mux; results forced to zero when disabled
    always_comb begin
        case (sel_reg)
            `AESC_SEL_CTRRES: rdwin = pass_reg ? ctr_reg : '0;
            `AESC_SEL_MAC,
            `AESC_SEL_CBCRES: rdwin = pass_reg ? cbc_reg : '0;
            default:          rdwin = '0;
        endcase
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        ctl_next = ctl_reg;
        run_next = run_reg;
        st_next  = st_reg;
        sel_next = sel_reg;
        pass_next = pass_reg;
        done_next = done_reg;
        cdone_next = cdone_reg;
        key_next = key_reg;
        txt_next = txt_reg;
        cnt_next = cnt_reg;
        stg_next = stg_reg;
        ctr_next = ctr_reg;
        cbc_next = cbc_reg;
        blk_next = blk_reg;
        rk_next  = rk_reg;
        rc_next  = rc_reg;
        rnd_next = rnd_reg;
        prd_next = prd_reg;
        // self-clearing bits drop after one cycle
        ctl_next.start    = 1'b0;
        ctl_next.clear    = 1'b0;
        ctl_next.accumulator_load_bit = 1'b0;
        if (rd_setup) begin
            case (paddr)
                `AESC_OFS_CTRL1: prd_next = 32'(ctl_reg);
                `AESC_OFS_CTRL2: prd_next = 32'({sel_reg, 3'b000, st_reg != AESC_IDLE, pass_reg});
                `AESC_OFS_IRQS2: prd_next = 32'(done_reg);
                default: prd_next = (paddr >= `AESC_OFS_DATA0 && paddr <= `AESC_OFS_DATA3) ?
                                    rdwin[127 - 32 * widx -: 32] : '0;
            endcase
        end
        // core: one round per clock, complete level held until next launch
        if (rnd_reg != 4'h0) begin
            blk_next = cout;
            rk_next  = kx;
            rc_next  = xt(rc_reg);
            rnd_next = rdy ? 4'h0 : rnd_reg + 4'h1;
            cdone_next = rdy;
        end
        // wrapper capture at the ready pulse
        if (rdy && st_reg == AESC_CTR_P) begin
            ctr_next = cout ^ txt_reg;
            st_next  = chain ? AESC_CBC_P : AESC_IDLE;
            done_next = done_next | !chain;
        end
        if (rdy && st_reg == AESC_CBC_P) begin
            cbc_next  = cout;
            st_next   = AESC_IDLE;
            done_next = 1'b1;
            if (run_reg.selftest) begin
                pass_next = cout == SELFTEST_EXPECT;
            end
        end
        if (launch || chain) begin
            blk_next = cin ^ ckey;
            rk_next  = ckey;
            rc_next  = `AESC_RCON0;
            rnd_next = 4'h1;
            cdone_next = 1'b0;
            if (launch) begin
                run_next = ctl_reg;
                st_next  = go_ctr ? AESC_CTR_P : (go_cbc ? AESC_CBC_P : AESC_IDLE);
            end
        end
        // register writes; hardware set of the done flag wins over w1c
        if (wr) begin
            case (paddr)
                `AESC_OFS_CTRL1: ctl_next = aesc_ctrl_type'(pwdata[`AESC_CTRL1_W-1:0]);
                `AESC_OFS_CTRL2: sel_next = pwdata[`AESC_SEL_HI:`AESC_SEL_LO];
                `AESC_OFS_IRQS2: done_next = done_next & ~(pwdata[`AESC_DONE_BIT] & ~done_next
                                              | pwdata[`AESC_DONE_BIT] & done_reg
                                                & !(rdy && st_reg != AESC_IDLE && !chain));
                default: begin
                    for (int b = 0; b < 4; b++) begin
                        if (pstrb[b]) begin
                            case (sel_reg)
                                `AESC_SEL_KEY:   key_next[wbase + 8 * b +: 8] = pwdata[8*b +: 8];
                                `AESC_SEL_TEXT:  txt_next[wbase + 8 * b +: 8] = pwdata[8*b +: 8];
                                `AESC_SEL_CNT:   cnt_next[wbase + 8 * b +: 8] = pwdata[8*b +: 8];
                                `AESC_SEL_STAGE: stg_next[wbase + 8 * b +: 8] = pwdata[8*b +: 8];
                                default: ;
                            endcase
                        end
                    end
                end
            endcase
        end
        // clear and preload act on the accumulators, over any capture
        if (ctl_reg.accumulator_load_bit) begin
            cbc_next = stg_reg;
        end
        if (ctl_reg.clear) begin
            ctr_next = '0;
            cbc_next = '0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= '0;
            run_reg <= '0;
            st_reg  <= AESC_IDLE;
            sel_reg <= `AESC_SEL_KEY;
            pass_reg <= 1'b0;
            done_reg <= 1'b0;
            cdone_reg <= 1'b0;
            key_reg <= '0;
            txt_reg <= '0;
            cnt_reg <= '0;
            stg_reg <= '0;
            ctr_reg <= '0;
            cbc_reg <= '0;
            blk_reg <= '0;
            rk_reg  <= '0;
            rc_reg  <= '0;
            rnd_reg <= '0;
            prd_reg <= '0;
        end else begin
            ctl_reg <= ctl_next;
            run_reg <= run_next;
            st_reg  <= st_next;
            sel_reg <= sel_next;
            pass_reg <= pass_next;
            done_reg <= done_next;
            cdone_reg <= cdone_next;
            key_reg <= key_next;
            txt_reg <= txt_next;
            cnt_reg <= cnt_next;
            stg_reg <= stg_next;
            ctr_reg <= ctr_next;
            cbc_reg <= cbc_next;
            blk_reg <= blk_next;
            rk_reg  <= rk_next;
            rc_reg  <= rc_next;
            rnd_reg <= rnd_next;
            prd_reg <= prd_next;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rounds;
        (rnd_reg != 4'h0 && !rdy) [*8] ##1 (rnd_reg != 4'h0 && !rdy) ##1 rdy;
    endsequence
    sequence s_launch;
        launch && !ctl_reg.clear && !ctl_reg.accumulator_load_bit;
    endsequence
    AST_START_SC: assert property (ctl_reg.start |=> !ctl_reg.start)
        else $error("start stuck");
    AST_ROUNDS: assert property (launch |=> s_rounds) else $error("round count wrong");
    AST_LAT: assert property ((s_launch and !go_ctr) |-> ##10 rdy ##1 (cdone_reg && done_reg))
        else $error("result not ready at 11 clocks");
    AST_RES11: assert property ((s_launch and ((ctl_reg.cbc || ctl_reg.aes) && !ctl_reg.ctr
        && !ctl_reg.selftest)) |-> ##11 cbc_reg == $past(cout))
        else $error("chaining result late");
    AST_IGNORE: assert property (ctl_reg.start && !pass_reg && !ctl_reg.selftest
        && st_reg == AESC_IDLE |=> st_reg == AESC_IDLE && rnd_reg == 4'h0)
        else $error("disabled engine started");
    AST_ZERO: assert property (!pass_reg && rd_setup && paddr >= `AESC_OFS_DATA0 |=> prdata == '0)
        else $error("disabled result not zero");
    AST_CLEAR: assert property (ctl_reg.clear |=> ctr_reg == '0 && cbc_reg == '0)
        else $error("clear failed");
    AST_CTRX: assert property (rdy && st_reg == AESC_CTR_P && !ctl_reg.clear
        |=> ctr_reg == $past(cout ^ txt_reg)) else $error("counter xor wrong");
    AST_CCM: assert property (chain |=> st_reg == AESC_CBC_P ##9 rdy)
        else $error("chaining pass missing");
    AST_LOAD: assert property (ctl_reg.accumulator_load_bit && !ctl_reg.clear
        |=> cbc_reg == $past(stg_reg))
        else $error("preload failed");
endmodule // aesc_engine

// >>> verification/aesc_host.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// host software model: apb master driving the register file
// ------------------------------------------------------------
module aesc_host import aesc_pkg::*; (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // bus idle from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'hF;
    end

    // one transfer; waits for pready as long as it takes, the bench watchdog ends a hang
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;  // released data must not keep its last value
    endtask
endmodule // aesc_host

// >>> verification/test_aes_ctr_cbc_ccm_engine.sv
`timescale 1ns/100ps
`include "aesc_regs.svh"
module test_aes_ctr_cbc_ccm_engine import aesc_pkg::*;;
    // ------------------------------------------------------------
    // signals and constants
    // ------------------------------------------------------------
    localparam logic [127:0] ENC0 = 128'h66E9_4BD4_EF8A_2C3B_884C_FA59_CA34_2B2E;
    localparam logic [127:0] TXT  = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    localparam logic [127:0] STG  = 128'hA5A5_0F0F_1234_8765_5A5A_F0F0_4321_7856;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        done_irq;
    int          errors;
    int          tests_run;
    logic [127:0] v;
    logic [31:0] q;
    logic        e;
    // 40 mhz clock
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;
    // ------------------------------------------------------------
    // device and host
    // ------------------------------------------------------------
    aesc_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .done_irq(done_irq));
    aesc_host host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ------------------------------------------------------------
    // bus helpers and compares
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        host.xfer(1'b1, a, d, x, y);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic y;
        host.xfer(1'b0, a, 32'h0000_0000, d, y);
    endtask
    // the select must be set before every window access, it steers both ways
    task automatic wr128(input logic [2:0] s, input logic [127:0] d);
        wr(`AESC_OFS_CTRL2, {24'h00_0000, s, 5'h00});
        for (int k = 0; k < 4; k++) wr(12'(`AESC_OFS_DATA0 + 4 * k), d[127 - 32 * k -: 32]);
    endtask
    task automatic rd128(input logic [2:0] s, output logic [127:0] d);
        logic [31:0] w;
        wr(`AESC_OFS_CTRL2, {24'h00_0000, s, 5'h00});
        for (int k = 0; k < 4; k++) begin
            rd(12'(`AESC_OFS_DATA0 + 4 * k), w);
            d[127 - 32 * k -: 32] = w;
        end
    endtask
    task automatic chk_val(input string nm, input logic [127:0] x, input logic [127:0] g);
        tests_run++;
        if (g !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic chk_cyc(input string nm, input int x, input int g);
        tests_run++;
        if (g != x) begin
            errors++;
            $display("wrong value %s expected %0d seen %0d", nm, x, g);
        end
    endtask
    // start, time the completion level, then clear it by write-one
    task automatic run(input logic [31:0] c, input int x);
        int n;
        n = 0;
        wr(`AESC_OFS_CTRL1, c);
        while (done_irq !== 1'b1 && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk_cyc("latency", x, n);
        rd(`AESC_OFS_IRQS2, q);
        chk_val("status", 128'h1, {127'h0, q[0]});
        wr(`AESC_OFS_IRQS2, 32'h0000_0001);
        #1;
        chk_val("irq cleared", 128'h0, {127'h0, done_irq});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_locked();
        rd(`AESC_OFS_CTRL2, q);
        chk_val("pass at reset", 128'h0, {127'h0, q[0]});
        wr(`AESC_OFS_CTRL1, 32'h0000_0009);
        repeat (30) @(posedge pclk);
        #1;
        chk_val("locked start", 128'h0, {127'h0, done_irq});
        wr(`AESC_OFS_CTRL1, 32'h0000_0000);
    endtask
    task automatic t_selftest();
        wr(`AESC_OFS_CTRL1, 32'h0000_0020);
        wr128(`AESC_SEL_TEXT, 128'h0);
        wr(`AESC_OFS_CTRL1, 32'h0000_0010);
        run(32'h0000_0011, 11);
        rd(`AESC_OFS_CTRL1, q);
        chk_val("start self clear", 128'h10, {120'h0, q[7:0]});
        rd(`AESC_OFS_CTRL2, q);
        chk_val("pass flag", 128'h1, {127'h0, q[0]});
        rd128(`AESC_SEL_CBCRES, v);
        chk_val("selftest out", ENC0, v);
        wr(`AESC_OFS_CTRL1, 32'h0000_0000);
    endtask
    task automatic t_ctr();
        wr128(`AESC_SEL_KEY, 128'h0);
        wr128(`AESC_SEL_TEXT, TXT);
        wr128(`AESC_SEL_CNT, 128'h0);
        run(32'h0000_0003, 11);
        rd128(`AESC_SEL_CTRRES, v);
        chk_val("ctr result", ENC0 ^ TXT, v);
        wr128(`AESC_SEL_TEXT, ENC0 ^ TXT);
        run(32'h0000_0003, 11);
        rd128(`AESC_SEL_CTRRES, v);
        chk_val("ctr decrypt", TXT, v);
    endtask
    task automatic t_aes();
        wr(`AESC_OFS_CTRL1, 32'h0000_0020);
        wr128(`AESC_SEL_TEXT, 128'h0);
        run(32'h0000_0009, 11);
        rd128(`AESC_SEL_CBCRES, v);
        chk_val("aes result", ENC0, v);
        rd128(`AESC_SEL_CTRRES, v);
        chk_val("ctr cleared", 128'h0, v);
    endtask
    task automatic t_ccm();
        wr(`AESC_OFS_CTRL1, 32'h0000_0020);
        wr128(`AESC_SEL_CNT, 128'h0);
        run(32'h0000_0007, 21);
        rd128(`AESC_SEL_CTRRES, v);
        chk_val("ccm ctr", ENC0, v);
        rd128(`AESC_SEL_MAC, v);
        chk_val("ccm mac", ENC0, v);
    endtask
    task automatic t_unmapped();
        host.xfer(1'b0, 12'h0F0, 32'h0000_0000, q, e);
        chk_val("unmapped err", 128'h1, {127'h0, e});
        chk_val("unmapped data", 128'h0, {96'h0, q});
    endtask
    // a nonzero accumulator becomes the test key, so the self-test must fail
    task automatic t_fail();
        wr128(`AESC_SEL_STAGE, STG);
        wr(`AESC_OFS_CTRL1, 32'h0000_0040);
        rd128(`AESC_SEL_MAC, v);
        chk_val("loaded acc", STG, v);
        wr(`AESC_OFS_CTRL1, 32'h0000_0010);
        run(32'h0000_0011, 11);
        rd(`AESC_OFS_CTRL2, q);
        chk_val("fail flag", 128'h0, {127'h0, q[0]});
        rd128(`AESC_SEL_CBCRES, v);
        chk_val("fail output", 128'h0, v);
        wr(`AESC_OFS_CTRL1, 32'h0000_0000);
    endtask
    // ------------------------------------------------------------
    // sequence, verdict and watchdog
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        errors = 0;
        tests_run = 0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_locked();
        t_selftest();
        t_ctr();
        t_aes();
        t_ccm();
        t_unmapped();
        t_fail();
        report_and_stop();
    end
    // the whole run needs about five hundred cycles
    initial begin
        #500000;
        errors++;
        report_and_stop();
    end
endmodule // test_aes_ctr_cbc_ccm_engine
